/* File: common/serial_config_pkg.sv */
// constants, register map and states of the configuration pin block
// assumes a 20 MHz register clock and an AXI4-Lite master with 32-bit data
`default_nettype none
package serial_config_pkg;

  localparam int unsigned REF_CLK_HZ       = 20_000_000;
  localparam int unsigned AS_CLOCK_HZ      = 2_500_000;
  localparam int unsigned AS_HALF_CYCLES   = REF_CLK_HZ / (2 * AS_CLOCK_HZ);
  localparam logic [3:0]  AS_HALF_LAST     = 4'(AS_HALF_CYCLES - 1);

  localparam int unsigned ADDR_W           = 8;
  localparam int unsigned DATA_W           = 32;
  localparam int unsigned COUNT_W          = 16;
  localparam int unsigned BIT_CNT_W        = 5;
  localparam int unsigned USER_IO_W        = 8;
  localparam int unsigned OPT_PINS         = 4;
  localparam int unsigned SYNC_W           = 6;

  localparam logic [ADDR_W-1:0] REG_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] REG_WORD_COUNT = 8'h04;
  localparam logic [ADDR_W-1:0] REG_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] REG_LAST_WORD  = 8'h0C;

  localparam int unsigned CTRL_SCHEME_BIT      = 0;
  localparam logic        CTRL_SCHEME_RESET    = 1'b0;
  localparam logic [COUNT_W-1:0] WORD_COUNT_RESET = 16'h0004;
  localparam int unsigned STATUS_STATE_LSB     = 0;
  localparam int unsigned STATUS_OPT_LSB       = 4;
  localparam int unsigned STATUS_OPT_LOADED    = 8;
  localparam int unsigned STATUS_WORDS_LSB     = 16;

  // option bits of the first word, also optional pin indices
  localparam int unsigned OPT_USER_CLOCK   = 0;
  localparam int unsigned OPT_INIT_DONE    = 1;
  localparam int unsigned OPT_GLOBAL_OE    = 2;
  localparam int unsigned OPT_GLOBAL_CLEAR = 3;

  // synchroniser lanes
  localparam int unsigned SY_REQUEST = 0;
  localparam int unsigned SY_DATA    = 1;
  localparam int unsigned SY_UCLK    = 2;
  localparam int unsigned SY_OE      = 3;
  localparam int unsigned SY_CLEAR   = 4;
  localparam int unsigned SY_TOGGLE  = 5;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h18;

  localparam logic [COUNT_W-1:0] INIT_CLOCKS = 16'h012B;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [3:0] {
    ST_HOLD = 4'b0001,
    ST_LOAD = 4'b0010,
    ST_INIT = 4'b0100,
    ST_USER = 4'b1000
  } cfg_state_e;

endpackage
`default_nettype wire

/* File: design/serial_config_pin_control.sv */
// serial configuration pins: serial loading, init-done, global overrides
// optional start-up clock pacing
// assumes config_clock_in is the resolved clock pin; AXI4-Lite master
//
// Local design decisions: register access over AXI4-Lite and the address map.
`default_nettype none
// Overview of operation
// - passive serial: host clock, data bit taken on its rising edge
// - active serial: device drives the clock that times loading
// - clock pin released after loading; later toggling ignored
// - configuration data arrives serially on one data input
// - disabled optional pins are user I/O, tri-stated during configuration
// - enabled user start-up clock times the initialization count
// - init-done pin undriven while request is low and at loading start
// - init-done pin pulled low once its enable bit loads in the first word
// - init-done released at end of initialization; user mode entered
// - enabled global output enable low floats every user I/O
// - enabled global output enable high lets user I/O drive as programmed
// - enabled global clear low holds all device registers cleared
// - enabled global clear high lets registers behave as programmed
module serial_config_pin_control
  import serial_config_pkg::*;
(
  input  wire logic                  ref_clk_in,
  input  wire logic                  srst_in,
  input  wire logic [ADDR_W-1:0]     s_axi_awaddr_in,
  input  wire logic                  s_axi_awvalid_in,
  output logic                       s_axi_awready_out,
  input  wire logic [DATA_W-1:0]     s_axi_wdata_in,
  input  wire logic [3:0]            s_axi_wstrb_in,
  input  wire logic                  s_axi_wvalid_in,
  output logic                       s_axi_wready_out,
  output logic [1:0]                 s_axi_bresp_out,
  output logic                       s_axi_bvalid_out,
  input  wire logic                  s_axi_bready_in,
  input  wire logic [ADDR_W-1:0]     s_axi_araddr_in,
  input  wire logic                  s_axi_arvalid_in,
  output logic                       s_axi_arready_out,
  output logic [DATA_W-1:0]          s_axi_rdata_out,
  output logic [1:0]                 s_axi_rresp_out,
  output logic                       s_axi_rvalid_out,
  input  wire logic                  s_axi_rready_in,
  input  wire logic                  config_clock_in,
  output logic                       config_clock_out,
  output logic                       config_clock_oe_out,
  input  wire logic                  serial_config_data_in,
  input  wire logic                  config_request_n_in,
  input  wire logic                  user_startup_clock_in,
  input  wire logic                  global_output_enable_in,
  input  wire logic                  global_register_clear_n_in,
  output logic                       init_done_out,
  output logic                       init_done_oe_out,
  input  wire logic [OPT_PINS-1:0]   opt_pin_user_data_in,
  input  wire logic [OPT_PINS-1:0]   opt_pin_user_oe_in,
  output logic [OPT_PINS-1:0]        opt_pin_data_out,
  output logic [OPT_PINS-1:0]        opt_pin_oe_out,
  input  wire logic [USER_IO_W-1:0]  user_io_data_in,
  input  wire logic [USER_IO_W-1:0]  user_io_oe_in,
  output logic [USER_IO_W-1:0]       user_io_data_out,
  output logic [USER_IO_W-1:0]       user_io_oe_out,
  output logic                       device_registers_clear_out,
  output logic                       user_mode_out
);

  cfg_state_e            state;
  logic                  scheme_active;
  logic [COUNT_W-1:0]    word_count;
  logic [DATA_W-1:0]     last_word;
  logic [OPT_PINS-1:0]   options;
  logic                  opt_loaded;
  logic [COUNT_W-1:0]    words_rx;
  logic [COUNT_W-1:0]    init_cnt;
  logic [SYNC_W-1:0]     sync_raw;
  logic [SYNC_W-1:0]     sync_meta;
  logic [SYNC_W-1:0]     sync_q;
  logic                  toggle_seen;
  logic                  uclk_prev;
  logic                  link_arm;
  logic [1:0]            arm_sync;
  logic [BIT_CNT_W-1:0]  link_bit_cnt;
  logic [DATA_W-1:0]     link_shift;
  logic [DATA_W-1:0]     link_word;
  logic                  link_toggle;
  logic [3:0]            as_div;
  logic                  as_clk;
  logic [BIT_CNT_W-1:0]  as_bit_cnt;
  logic [DATA_W-1:0]     as_shift;
  logic                  as_word_done;
  logic                  word_valid;
  logic [DATA_W-1:0]     word_data;
  logic                  last_of_frame;
  logic                  init_tick;
  logic                  oe_gate;
  logic                  aw_held;
  logic                  w_held;
  logic [ADDR_W-1:0]     aw_addr;
  logic [DATA_W-1:0]     w_data;
  logic [3:0]            w_strb;

  ////////////////////////////////////////////////////////////////////////////////
  // pin synchronisers, two flops each

  assign sync_raw = {link_toggle, global_register_clear_n_in, global_output_enable_in,
                     user_startup_clock_in, serial_config_data_in, config_request_n_in};

  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++) begin : g_sync
      always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
          sync_meta[gi] <= SYNC_RESET[gi];
          sync_q[gi]    <= SYNC_RESET[gi];
        end else begin
          sync_meta[gi] <= sync_raw[gi];
          sync_q[gi]    <= sync_meta[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      toggle_seen <= 1'b0;
      uclk_prev   <= 1'b0;
    end else begin
      toggle_seen <= sync_q[SY_TOGGLE];
      uclk_prev   <= sync_q[SY_UCLK];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // passive serial receiver on the host's clock

  // armed only during passive loading; later toggling is ignored
  assign link_arm = !scheme_active && (state == ST_LOAD);

  always_ff @(posedge config_clock_in) begin
    arm_sync <= {arm_sync[0], link_arm};
  end

  // clock may stop between frames; the word holds until 32 more bits
  always_ff @(posedge config_clock_in) begin
    if (!arm_sync[1]) begin
      link_bit_cnt <= '0;
      link_shift   <= '0;
      link_toggle  <= 1'b0;
    end else begin
      link_shift   <= {serial_config_data_in, link_shift[DATA_W-1:1]};
      link_bit_cnt <= link_bit_cnt + 1'b1;
      if (link_bit_cnt == BIT_CNT_W'(DATA_W - 1)) begin
        link_word   <= {serial_config_data_in, link_shift[DATA_W-1:1]};
        link_toggle <= ~link_toggle;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // active serial: divided clock driven out

  always_ff @(posedge ref_clk_in) begin
    if (srst_in || !scheme_active || state != ST_LOAD) begin
      as_div       <= '0;
      as_clk       <= 1'b0;
      as_bit_cnt   <= '0;
      as_shift     <= '0;
      as_word_done <= 1'b0;
    end else begin
      as_word_done <= 1'b0;
      if (as_div == AS_HALF_LAST) begin
        as_div <= '0;
        as_clk <= ~as_clk;
        // sample on our rising edge, half a period after the memory's change
        if (!as_clk) begin
          as_shift   <= {sync_q[SY_DATA], as_shift[DATA_W-1:1]};
          as_bit_cnt <= as_bit_cnt + 1'b1;
          if (as_bit_cnt == BIT_CNT_W'(DATA_W - 1)) begin
            as_word_done <= 1'b1;
          end
        end
      end else begin
        as_div <= as_div + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      config_clock_out    <= 1'b0;
      config_clock_oe_out <= 1'b0;
    end else begin
      config_clock_out    <= as_clk;
      config_clock_oe_out <= scheme_active && (state == ST_LOAD);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // load sequencing

  assign word_valid = scheme_active ? as_word_done
                                    : (sync_q[SY_TOGGLE] != toggle_seen);
  assign word_data  = scheme_active ? as_shift : link_word;
  assign last_of_frame = (words_rx + 1'b1) >= word_count;
  // start-up clock edges pace initialization only when enabled
  assign init_tick = options[OPT_USER_CLOCK] ? (sync_q[SY_UCLK] && !uclk_prev) : 1'b1;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      state      <= ST_HOLD;
      options    <= '0;
      opt_loaded <= 1'b0;
      words_rx   <= '0;
      init_cnt   <= '0;
      last_word  <= '0;
    end else if (!sync_q[SY_REQUEST]) begin
      state      <= ST_HOLD;
      options    <= '0;
      opt_loaded <= 1'b0;
      words_rx   <= '0;
      init_cnt   <= '0;
    end else begin
      case (state)
        ST_HOLD: begin
          state <= ST_LOAD;
        end
        ST_LOAD: begin
          if (word_valid) begin
            last_word <= word_data;
            if (!opt_loaded) begin
              options    <= word_data[OPT_PINS-1:0];
              opt_loaded <= 1'b1;
              if (word_count == '0) begin
                state <= ST_INIT;
              end
            end else begin
              words_rx <= words_rx + 1'b1;
              if (last_of_frame) begin
                state <= ST_INIT;
              end
            end
          end
        end
        ST_INIT: begin
          if (init_tick) begin
            init_cnt <= init_cnt + 1'b1;
            if (init_cnt == INIT_CLOCKS - 1'b1) begin
              state <= ST_USER;
            end
          end
        end
        ST_USER: begin
          state <= ST_USER;
        end
        default: begin
          state <= ST_HOLD;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pins and global overrides

  // low or floating only; the board pull-up makes the high level
  assign init_done_out = 1'b0;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      init_done_oe_out <= 1'b0;
    end else begin
      // floats until an option word with the init-done bit set lands, then low until user mode
      init_done_oe_out <= opt_loaded && options[OPT_INIT_DONE]
                          && (state == ST_LOAD || state == ST_INIT);
    end
  end

  assign oe_gate = !(options[OPT_GLOBAL_OE] && !sync_q[SY_OE]);

  generate
    for (gi = 0; gi < OPT_PINS; gi++) begin : g_opt_pin
      always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
          opt_pin_data_out[gi] <= 1'b0;
          opt_pin_oe_out[gi]   <= 1'b0;
        end else begin
          opt_pin_data_out[gi] <= options[gi] ? 1'b0 : opt_pin_user_data_in[gi];
          // disabled option: user I/O, floating until user mode
          opt_pin_oe_out[gi]   <= !options[gi] && (state == ST_USER)
                                  && opt_pin_user_oe_in[gi] && oe_gate;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      user_io_data_out <= '0;
      user_io_oe_out   <= '0;
    end else begin
      user_io_data_out <= user_io_data_in;
      user_io_oe_out   <= (state == ST_USER && oe_gate) ? user_io_oe_in : '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      device_registers_clear_out <= 1'b0;
      user_mode_out              <= 1'b0;
    end else begin
      device_registers_clear_out <= options[OPT_GLOBAL_CLEAR]
                                    && !sync_q[SY_CLEAR];
      user_mode_out              <= (state == ST_USER);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave: address and data in either order

  assign s_axi_awready_out = !aw_held && !s_axi_bvalid_out;
  assign s_axi_wready_out  = !w_held && !s_axi_bvalid_out;
  assign s_axi_arready_out = !s_axi_rvalid_out;

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      aw_held          <= 1'b0;
      w_held           <= 1'b0;
      aw_addr          <= '0;
      w_data           <= '0;
      w_strb           <= '0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out  <= RESP_OKAY;
      scheme_active    <= CTRL_SCHEME_RESET;
      word_count       <= WORD_COUNT_RESET;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr_in;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata_in;
        w_strb <= s_axi_wstrb_in;
      end
      if (aw_held && w_held) begin
        aw_held          <= 1'b0;
        w_held           <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= RESP_OKAY;
        case (aw_addr)
          REG_CTRL: begin
            // scheme fixed during a load
            if (w_strb[0] && state != ST_LOAD) begin
              scheme_active <= w_data[CTRL_SCHEME_BIT];
            end
          end
          REG_WORD_COUNT: begin
            if (w_strb[0]) begin
              word_count[7:0] <= w_data[7:0];
            end
            if (w_strb[1]) begin
              word_count[15:8] <= w_data[15:8];
            end
          end
          REG_STATUS, REG_LAST_WORD: begin
            s_axi_bresp_out <= RESP_OKAY;
          end
          default: begin
            s_axi_bresp_out <= RESP_SLVERR;
          end
        endcase
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (srst_in) begin
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out  <= '0;
      s_axi_rresp_out  <= RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_rvalid_out <= 1'b1;
      s_axi_rresp_out  <= RESP_OKAY;
      s_axi_rdata_out  <= '0;
      case (s_axi_araddr_in)
        REG_CTRL: begin
          s_axi_rdata_out[CTRL_SCHEME_BIT] <= scheme_active;
        end
        REG_WORD_COUNT: begin
          s_axi_rdata_out[COUNT_W-1:0] <= word_count;
        end
        REG_STATUS: begin
          s_axi_rdata_out[STATUS_STATE_LSB +: 4]        <= state;
          s_axi_rdata_out[STATUS_OPT_LSB +: OPT_PINS]   <= options;
          s_axi_rdata_out[STATUS_OPT_LOADED]            <= opt_loaded;
          s_axi_rdata_out[STATUS_WORDS_LSB +: COUNT_W]  <= words_rx;
        end
        REG_LAST_WORD: begin
          s_axi_rdata_out <= last_word;
        end
        default: begin
          s_axi_rresp_out <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out <= 1'b0;
    end
  end

endmodule // serial_config_pin_control
`default_nettype wire

/* File: verif/serial_config_sva.sv */
// assertions on the pins of the serial configuration block
// bound to the top module; sees its ports only, one clock domain
`default_nettype none
module serial_config_sva
  import serial_config_pkg::*;
(
  input wire logic                 ref_clk_in,
  input wire logic                 srst_in,
  input wire logic                 config_request_n_in,
  input wire logic                 global_register_clear_n_in,
  input wire logic [USER_IO_W-1:0] user_io_oe_in,
  input wire logic                 config_clock_out,
  input wire logic                 config_clock_oe_out,
  input wire logic                 init_done_out,
  input wire logic                 init_done_oe_out,
  input wire logic                 user_mode_out,
  input wire logic                 device_registers_clear_out,
  input wire logic [USER_IO_W-1:0] user_io_oe_out,
  input wire logic [OPT_PINS-1:0]  opt_pin_oe_out
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (srst_in);
  //////////////////////////////////////////////////////////////
  // a driven half period is four reference cycles
  sequence s_high_half;
    config_clock_out [*3] ##1 !config_clock_out;
  endsequence
  sequence s_let_go;
    ##[0:3] !config_clock_oe_out;
  endsequence
  property p_clock_half;
    $rose(config_clock_out) && config_clock_oe_out |=> s_high_half or s_let_go;
  endproperty
  property p_clock_free; user_mode_out |-> !config_clock_oe_out; endproperty
  property p_done_low; !init_done_out; endproperty
  // synchroniser and state change fit in five cycles
  property p_done_idle; !config_request_n_in [*5] |-> !init_done_oe_out; endproperty
  property p_done_pull; $rose(init_done_oe_out) |-> config_request_n_in && !user_mode_out;
  endproperty
  property p_done_free; $rose(user_mode_out) |-> !init_done_oe_out; endproperty
  property p_io_quiet;
    !user_mode_out && !$past(user_mode_out) |-> user_io_oe_out == '0 && opt_pin_oe_out == '0;
  endproperty
  property p_io_asked; (user_io_oe_out & ~$past(user_io_oe_in)) == '0; endproperty
  property p_clear_idle;
    global_register_clear_n_in [*6] |-> !device_registers_clear_out;
  endproperty
  a_clock_half: assert property (p_clock_half) else $error("clock half period wrong");
  a_clock_free: assert property (p_clock_free) else $error("clock driven in user mode");
  a_done_low: assert property (p_done_low) else $error("init done driven high");
  a_done_idle: assert property (p_done_idle) else $error("init done pulled in hold");
  a_done_pull: assert property (p_done_pull) else $error("init done pulled too late");
  a_done_free: assert property (p_done_free) else $error("init done held in user");
  a_io_quiet: assert property (p_io_quiet) else $error("pin driven while loading");
  a_io_asked: assert property (p_io_asked) else $error("pin driven unasked");
  a_clear_idle: assert property (p_clear_idle) else $error("clear without pin");
endmodule // serial_config_sva
`default_nettype wire

/* File: verif/config_source_model.sv */
// configuration source: passive host or active-serial memory
// drives clock and data pins; the bench resolves the clock wire
`default_nettype none
module config_source_model (
  input  wire logic        go_in,
  input  wire logic        active_in,
  input  wire logic        req_n_in,
  input  wire logic        clk_in,
  input  wire logic        idone_in,
  input  wire logic [3:0]  opts_in,
  input  wire logic [31:0] base_in,
  input  wire logic [3:0]  words_in,
  output logic             clk_out,
  output logic             clk_oe_out,
  output logic             data_out,
  output logic             done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [31:0] w;
  //////////////////////////////////////////////////////////////
  task pulse();
    #8 clk_out = 1'b1;
    #16 clk_out = 1'b0;
    #8;
  endtask
  initial begin
    {clk_out, clk_oe_out, data_out, done_out} = 4'h2;
    forever begin
      @(posedge go_in);
      {clk_oe_out, done_out} = 2'b10;
      // edges with the request low clear the link side
      repeat (4) pulse();
      clk_oe_out = !active_in;
      wait (req_n_in === 1'b1);
      if (!active_in) begin
        #307;
        repeat (2) pulse();
      end
      for (int i = 0; i < 32 * (32'(words_in) + 1); i++) begin
        w = (i < 32) ? {28'h0, opts_in} : base_in + 32'(i / 32 - 1);
        if (active_in && i > 0) @(negedge clk_in);
        data_out = w[i % 32];
        if (active_in) @(posedge clk_in);
        else pulse();
      end
      data_out = ~data_out;
      done_out = 1'b1;
      if (active_in) {clk_oe_out, clk_out} = 2'b10;
      else begin
        @(posedge idone_in);
        // late toggling, which the device must ignore
        repeat (8) begin
          data_out = ~data_out;
          pulse();
        end
      end
    end
  end
endmodule // config_source_model
`default_nettype wire

/* File: verif/tb_top.sv */
// self-checking bench for the configuration pin block
// drives the register bus and pins; a source model drives the link
`default_nettype none
module tb_top
  import serial_config_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, srst, awvalid, wvalid, bready, arvalid, rready, awready, wready;
  logic        bvalid, arready, rvalid, req_n, uclk, uclk_en, goe, gclr_n, go, act;
  logic        cclk_o, cclk_oe, idone, idone_oe, idone_pin, umode, rclr;
  logic        h_clk, h_oe, h_dat, h_done;
  logic [7:0]  awaddr, araddr, uio_d, uio_oe, uio_do, uio_oeo;
  logic [31:0] wdata, rdata, base;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb, od, ooe, oeo, opts, nwords;
  logic [33:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          miscompares, checked, seed, cycles;
  wire logic   cclk = cclk_oe ? cclk_o : (h_oe ? h_clk : 1'b1);
  always_comb idone_pin = idone_oe ? idone : 1'b1;
  //////////////////////////////////////////////////////////////
  serial_config_pin_control dut (
    .ref_clk_in(clk), .srst_in(srst), .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready), .s_axi_bresp_out(bresp),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready), .s_axi_araddr_in(araddr),
    .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready), .s_axi_rdata_out(rdata),
    .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .config_clock_in(cclk), .config_clock_out(cclk_o), .config_clock_oe_out(cclk_oe),
    .serial_config_data_in(h_dat), .config_request_n_in(req_n), .user_startup_clock_in(uclk),
    .global_output_enable_in(goe), .global_register_clear_n_in(gclr_n),
    .init_done_out(idone), .init_done_oe_out(idone_oe), .opt_pin_user_data_in(od),
    .opt_pin_user_oe_in(ooe), .opt_pin_data_out(), .opt_pin_oe_out(oeo),
    .user_io_data_in(uio_d), .user_io_oe_in(uio_oe), .user_io_data_out(uio_do),
    .user_io_oe_out(uio_oeo), .device_registers_clear_out(rclr), .user_mode_out(umode));
  config_source_model src (
    .go_in(go), .active_in(act), .req_n_in(req_n), .clk_in(cclk), .idone_in(idone_pin),
    .opts_in(opts), .base_in(base), .words_in(nwords), .clk_out(h_clk), .clk_oe_out(h_oe),
    .data_out(h_dat), .done_out(h_done));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////
  task final_report();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic compare(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int n = 0; s !== 1'b1 && n < lim; n++) @(posedge clk);
    compare(34'(s), 34'h1);
  endtask
  task axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    @(posedge clk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hF, 3'b111};
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (!bvalid) @(posedge clk);
    bready <= 1'b0;
  endtask
  task axi_rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_r.push_back({r, d});
    @(posedge clk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge clk);
    rready <= 1'b0;
  endtask
  // option word, n data words, then initialization
  task load(input logic a, input logic [3:0] o, input logic [3:0] n);
    axi_wr(REG_CTRL, {31'h0, a}, RESP_OKAY);
    axi_wr(REG_WORD_COUNT, {28'h0, n}, RESP_OKAY);
    @(posedge clk);
    base <= $random(seed);
    {act, opts, nwords, go} <= {a, o, n, 1'b1};
    repeat (10) @(posedge clk);
    {go, req_n} <= 2'b01;
    wait_hi(idone_oe, 2000);
    compare(34'({umode, cclk_oe, uio_oeo, oeo}), 34'({1'b0, a, 12'h0}));
    if (o[0]) begin
      wait_hi(h_done, 2000);
      repeat (400) @(posedge clk);
      compare(34'(umode), 34'h0);
      uclk_en <= 1'b1;
    end
    wait_hi(idone_pin, 3000);
    repeat (12) @(posedge clk);
    compare(34'({umode, cclk_oe}), 34'h2);
    axi_rd(REG_STATUS, {12'h0, n, 7'h0, 1'b1, o, 4'h8}, RESP_OKAY);
    axi_rd(REG_LAST_WORD, base + 32'(n) - 1, RESP_OKAY);
  endtask
  //////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    if (rvalid && rready) compare({rresp, rdata}, exp_r.pop_front());
    if (bvalid && bready) compare(34'(bresp), 34'(exp_b.pop_front()));
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (uclk_en && cycles[0]) uclk <= ~uclk;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end
  initial begin
    {miscompares, checked, cycles, seed} = {32'h0, 32'h0, 32'h0, 32'hDD62};
    {srst, go, act, uclk, uclk_en, req_n, goe, gclr_n} = 8'h83;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, base, opts, nwords} = '0;
    {uio_d, uio_oe, od} = 20'($random(seed));
    ooe = 4'($random(seed)) | 4'h1;
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    axi_rd(REG_CTRL, {31'h0, CTRL_SCHEME_RESET}, RESP_OKAY);
    axi_rd(REG_WORD_COUNT, {16'h0, WORD_COUNT_RESET}, RESP_OKAY);
    axi_rd(REG_STATUS, 32'h1, RESP_OKAY);
    axi_wr(8'h10, $random(seed), RESP_SLVERR);
    axi_rd(8'h10, 32'h0, RESP_SLVERR);
    load(1'b0, 4'hE, 4'h2);
    goe <= 1'b0;
    repeat (5) @(posedge clk);
    compare(34'({uio_oeo, oeo}), 34'h0);
    goe <= 1'b1;
    repeat (5) @(posedge clk);
    compare(34'({uio_oeo, uio_do, oeo}), 34'({uio_oe, uio_d, 3'h0, ooe[0]}));
    gclr_n <= 1'b0;
    repeat (5) @(posedge clk);
    compare(34'(rclr), 34'h1);
    gclr_n <= 1'b1;
    repeat (5) @(posedge clk);
    compare(34'(rclr), 34'h0);
    req_n <= 1'b0;
    repeat (6) @(posedge clk);
    compare(34'({umode, idone_oe}), 34'h0);
    load(1'b1, 4'hF, 4'h3);
    compare(34'(oeo), 34'h0);
    final_report();
  end
endmodule // tb_top
bind serial_config_pin_control serial_config_sva u_sva (
  .ref_clk_in(ref_clk_in), .srst_in(srst_in), .config_request_n_in(config_request_n_in),
  .global_register_clear_n_in(global_register_clear_n_in), .user_io_oe_in(user_io_oe_in),
  .config_clock_out(config_clock_out), .config_clock_oe_out(config_clock_oe_out),
  .init_done_out(init_done_out), .init_done_oe_out(init_done_oe_out),
  .user_mode_out(user_mode_out), .device_registers_clear_out(device_registers_clear_out),
  .user_io_oe_out(user_io_oe_out), .opt_pin_oe_out(opt_pin_oe_out));
`default_nettype wire
